// >>> verilog/sdpr_regs.svh
`ifndef SDPR_REGS_SVH
`define SDPR_REGS_SVH

// Port geometry
`define SDPR_ADDR_W          15
`define SDPR_DATA_W          16
`define SDPR_LANES           2

// Register byte offsets on the APB side
`define SDPR_OFF_CTRL        12'h000
`define SDPR_OFF_STATUS      12'h004
`define SDPR_OFF_ADDR        12'h008

// CTRL fields
`define SDPR_CTRL_PIPE_BIT   0
`define SDPR_CTRL_RESET      1'h0

// STATUS fields
`define SDPR_STAT_PDOWN_BIT  0
`define SDPR_STAT_MODE_BIT   1
`define SDPR_STAT_DRIVE_LSB  2

`endif

// >>> verilog/sdpr_pkg.sv
`include "sdpr_regs.svh"

package sdpr_pkg;

   typedef enum logic {
      SDPR_FLOW = 1'b0,
      SDPR_PIPE = 1'b1
   } sdpr_mode_e;

   // Synchronous control pins of one port, all active as on the pins
   typedef struct packed {
      logic rw_n;
      logic select_low_n;
      logic select_high;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
      logic addr_load_strobe_n;
      logic count_advance_n;
      logic count_clear_n;
   } sdpr_ctl_s;

endpackage

// >>> verilog/sdpr_addr_counter.sv
`timescale 1ns/1ps
`include "sdpr_regs.svh"

module sdpr_addr_counter #(
   parameter int ADDR_W = `SDPR_ADDR_W
) (
   input  wire logic              i_clock,
   input  wire logic              i_resetn,
   input  wire logic [ADDR_W-1:0] i_ext_addr,
   input  wire logic              i_addr_load_strobe_n,
   input  wire logic              i_count_advance_n,
   input  wire logic              i_count_clear_n,
   output logic      [ADDR_W-1:0] o_addr_int,
   output logic      [ADDR_W-1:0] o_count
);

   logic [ADDR_W-1:0] count;
   logic [ADDR_W-1:0] next_count;

   // Internal address is resolved from the pins sampled at this edge,
   // so the access of this cycle already sees the new value.
   always_comb begin
      if (!i_count_clear_n) begin
         o_addr_int = '0;
      end else if (!i_addr_load_strobe_n) begin
         o_addr_int = i_ext_addr;
      end else if (!i_count_advance_n) begin
         o_addr_int = count + {{(ADDR_W-1){1'b0}}, 1'b1};
      end else begin
         o_addr_int = count;
      end
      next_count = o_addr_int;
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign o_count = count;

endmodule // sdpr_addr_counter

// >>> verilog/sdpr_array.sv
`timescale 1ns/1ps
`include "sdpr_regs.svh"

module sdpr_array #(
   parameter int ADDR_W = `SDPR_ADDR_W,
   parameter int LANE_W = `SDPR_DATA_W / `SDPR_LANES,
   parameter int LANES  = `SDPR_LANES
) (
   input  wire logic                    i_clock,
   input  wire logic [LANES-1:0]        i_wr_lanes,
   input  wire logic [ADDR_W-1:0]       i_addr,
   input  wire logic [LANES*LANE_W-1:0] i_wdata,
   output logic      [LANES*LANE_W-1:0] o_rdata
);

   localparam int DEPTH = 2 ** ADDR_W;

   // One storage bank per byte lane keeps each lane single-driven
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [DEPTH];

      // Write completes at the capturing edge itself; nothing waits
      // for a later clock transition.
      always_ff @(posedge i_clock) begin
         if (i_wr_lanes[g]) begin
            lane_mem[i_addr] <= i_wdata[g*LANE_W +: LANE_W];
         end
      end

      assign o_rdata[g*LANE_W +: LANE_W] = lane_mem[i_addr];
   end

endmodule // sdpr_array

// >>> verilog/sdpr_top.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "sdpr_regs.svh"

module sdpr_top #(
   parameter int ADDR_W = `SDPR_ADDR_W,
   parameter int DATA_W = `SDPR_DATA_W
) (
   input  wire logic                I_CLOCK,
   input  wire logic                I_RESETN,
   input  wire logic [ADDR_W-1:0]   I_ADDR,
   input  wire logic [DATA_W-1:0]   I_DQ,
   input  wire sdpr_pkg::sdpr_ctl_s I_CTL,
   input  wire logic                I_OUTPUT_EN_N,
   output logic      [DATA_W-1:0]   O_DQ,
   output logic      [1:0]          O_DQ_OE,
   input  wire logic                I_PSEL,
   input  wire logic                I_PENABLE,
   input  wire logic                I_PWRITE,
   input  wire logic [11:0]         I_PADDR,
   input  wire logic [31:0]         I_PWDATA,
   output logic      [31:0]         O_PRDATA,
   output logic                     O_PREADY,
   output logic                     O_PSLVERR
);
   import sdpr_pkg::*;

   localparam int LANES  = `SDPR_LANES;
   localparam int LANE_W = DATA_W / LANES;

   // Decoded pin controls of this edge
   logic              sel_now;
   logic [LANES-1:0]  lane_en;
   logic [LANES-1:0]  wr_lanes;
   logic              rd_now;
   logic [ADDR_W-1:0] addr_int;
   logic [ADDR_W-1:0] count;
   logic [DATA_W-1:0] rdata;

   // Data path state
   sdpr_mode_e        mode;
   sdpr_mode_e        next_mode;
   logic [DATA_W-1:0] rd_q;
   logic [DATA_W-1:0] next_rd_q;
   logic [LANES-1:0]  pipe_drive;
   logic [LANES-1:0]  next_pipe_drive;
   logic              sel_q;
   logic              next_sel_q;
   logic [DATA_W-1:0] dq;
   logic [DATA_W-1:0] next_dq;
   logic [LANES-1:0]  dq_drive;
   logic [LANES-1:0]  next_dq_drive;
   logic              pdown;
   logic              next_pdown;

   // APB state
   logic              apb_setup;
   logic              apb_commit;
   logic [31:0]       prdata;
   logic [31:0]       next_prdata;
   logic              pready;
   logic              next_pready;
   logic              pslverr;
   logic              next_pslverr;
   logic [31:0]       rd_mux;
   logic              mapped;

   // Port decode; the pins are synchronous to I_CLOCK by contract
   always_comb begin
      sel_now  = ~I_CTL.select_low_n & I_CTL.select_high;
      lane_en  = {~I_CTL.upper_byte_sel_n, ~I_CTL.lower_byte_sel_n};
      // Held in reset the array takes no write
      wr_lanes = (I_RESETN && sel_now && !I_CTL.rw_n) ? lane_en : '0;
      rd_now   = sel_now & I_CTL.rw_n;
   end

   sdpr_addr_counter #(
      .ADDR_W (ADDR_W)
   ) u_counter (
      .i_clock              (I_CLOCK),
      .i_resetn             (I_RESETN),
      .i_ext_addr           (I_ADDR),
      .i_addr_load_strobe_n (I_CTL.addr_load_strobe_n),
      .i_count_advance_n    (I_CTL.count_advance_n),
      .i_count_clear_n      (I_CTL.count_clear_n),
      .o_addr_int           (addr_int),
      .o_count              (count)
   );

   sdpr_array #(
      .ADDR_W (ADDR_W),
      .LANE_W (LANE_W),
      .LANES  (LANES)
   ) u_array (
      .i_clock    (I_CLOCK),
      .i_wr_lanes (wr_lanes),
      .i_addr     (addr_int),
      .i_wdata    (I_DQ),
      .o_rdata    (rdata)
   );

   // Output path. Array read is before the write of the same edge;
   // a write cycle never drives, so that value is never seen.
   always_comb begin
      next_sel_q      = sel_now;
      next_pdown      = ~sel_now;
      next_rd_q       = rdata;
      // Pipe stage needs the select in this and the previous edge
      next_pipe_drive = (rd_now && sel_q) ? lane_en : '0;
      if (mode == SDPR_PIPE) begin
         next_dq       = rd_q;
         next_dq_drive = pipe_drive;
      end else begin
         next_dq       = rdata;
         next_dq_drive = rd_now ? lane_en : '0;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RESETN) begin
         sel_q      <= 1'b0;
         pdown      <= 1'b1;
         rd_q       <= '0;
         pipe_drive <= '0;
         dq         <= '0;
         dq_drive   <= '0;
      end else begin
         sel_q      <= next_sel_q;
         pdown      <= next_pdown;
         rd_q       <= next_rd_q;
         pipe_drive <= next_pipe_drive;
         dq         <= next_dq;
         dq_drive   <= next_dq_drive;
      end
   end

   assign O_DQ = dq;

   // Output enable gates the drive with no clock, for async buses;
   // this one output is therefore not a pure flop.
   assign O_DQ_OE = dq_drive & {LANES{~I_OUTPUT_EN_N}};

   // APB slave: zero-wait answer, pready high in the first access cycle
   always_comb begin
      apb_setup  = I_PSEL & ~I_PENABLE;
      apb_commit = I_PSEL & I_PENABLE & pready;
      mapped     = 1'b1;
      rd_mux     = '0;
      unique case (I_PADDR)
         `SDPR_OFF_CTRL: begin
            rd_mux[`SDPR_CTRL_PIPE_BIT] = mode;
         end
         `SDPR_OFF_STATUS: begin
            rd_mux[`SDPR_STAT_PDOWN_BIT]                   = pdown;
            rd_mux[`SDPR_STAT_MODE_BIT]                    = mode;
            rd_mux[`SDPR_STAT_DRIVE_LSB +: LANES]          = dq_drive;
         end
         `SDPR_OFF_ADDR: begin
            rd_mux[ADDR_W-1:0] = count;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase

      next_pready  = apb_setup;
      next_pslverr = apb_setup ? ~mapped : pslverr;
      next_prdata  = apb_setup ? ((I_PWRITE) ? '0 : rd_mux) : prdata;

      // Mode changes on a committed CTRL write, even while the port is in use
      next_mode = mode;
      if (apb_commit && I_PWRITE && I_PADDR == `SDPR_OFF_CTRL) begin
         next_mode = sdpr_mode_e'(I_PWDATA[`SDPR_CTRL_PIPE_BIT]);
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RESETN) begin
         mode    <= sdpr_mode_e'(`SDPR_CTRL_RESET);
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         mode    <= next_mode;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   assign O_PRDATA  = prdata;
   assign O_PREADY  = pready;
   assign O_PSLVERR = pslverr;

endmodule // sdpr_top

// >>> bench/sdpr_top_properties.sv
`timescale 1ns/1ps

module sdpr_top_properties
   import sdpr_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic              I_CLOCK,
   input wire logic              I_RESETN,
   input wire sdpr_ctl_s         I_CTL,
   input wire logic              I_OUTPUT_EN_N,
   input wire logic [DATA_W-1:0] O_DQ,
   input wire logic [1:0]        O_DQ_OE,
   input wire logic              I_PSEL,
   input wire logic              I_PENABLE,
   input wire logic [11:0]       I_PADDR,
   input wire logic [31:0]       O_PRDATA,
   input wire logic              O_PREADY,
   input wire logic              O_PSLVERR
);
   logic sel;
   logic setup;
   logic hold;
   assign sel = !I_CTL.select_low_n && I_CTL.select_high;
   assign setup = I_PSEL && !I_PENABLE;
   assign hold = sel && I_CTL.rw_n && I_CTL.addr_load_strobe_n && I_CTL.count_advance_n && I_CTL.count_clear_n;
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESETN);
   a_oe_async: assert property (I_OUTPUT_EN_N |-> O_DQ_OE == 2'h0)
      else $error("drive while output enable off");
   // Two edges so that both output modes are covered
   a_unsel_float: assert property (!sel ##1 !sel |=> O_DQ_OE == 2'h0)
      else $error("drive while deselected");
   a_write_float: assert property ((sel && !I_CTL.rw_n) [*2] |=> O_DQ_OE == 2'h0)
      else $error("drive after writes");
   a_byte_float: assert property (I_CTL.upper_byte_sel_n [*2] |=> !O_DQ_OE[1])
      else $error("upper lane driven while unselected");
   a_read_hold: assert property (hold [*3] |=> $stable(O_DQ))
      else $error("read data moved without address change");
   a_apb_ready: assert property (setup |=> O_PREADY)
      else $error("no ready in first access cycle");
   a_ready_cause: assert property (O_PREADY |-> $past(setup))
      else $error("ready without setup");
   a_apb_error: assert property (setup && I_PADDR > 12'h008 |=> O_PSLVERR && O_PRDATA == 32'h0)
      else $error("unmapped access not refused");
endmodule // sdpr_top_properties

bind sdpr_top sdpr_top_properties #(.DATA_W(DATA_W)) u_props (
   .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_CTL(I_CTL), .I_OUTPUT_EN_N(I_OUTPUT_EN_N), .O_DQ(O_DQ),
   .O_DQ_OE(O_DQ_OE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR));

// >>> bench/sdpr_host_model.sv
`timescale 1ns/1ps

module sdpr_host_model
   import sdpr_pkg::*;
(
   input  wire logic        i_clock,
   output logic      [14:0] o_addr,
   output logic      [15:0] o_dq,
   output sdpr_ctl_s        o_ctl
);
   initial begin
      o_addr = 15'h0;
      o_dq = 16'h0;
      o_ctl = 8'hC7;
   end
   // Flags: bank, rw_n, load_n, advance_n, clear_n, upper_n
   task automatic op(input logic [5:0] f, input logic [14:0] a, input logic [15:0] d);
      @(posedge i_clock);
      o_ctl <= '{f[4], ~f[5], f[5], f[0], 1'b0, f[3], f[2], f[1]};
      // Unused lines toggle so stale values never pass
      o_addr <= f[3] ? ~o_addr : a;
      o_dq <= f[4] ? ~o_dq : d;
   endtask
endmodule // sdpr_host_model

// >>> bench/sdpr_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end

module sdpr_top_test;
   import sdpr_pkg::*;
   localparam logic [5:0] WR_LD = 6'h26, WR_ADV = 6'h2A, RD_LD = 6'h36, RD_ADV = 6'h3A, RD_HOLD = 6'h3E;
   localparam logic [5:0] RD_CLR = 6'h3C, RD_LD_UB = 6'h37, RD_HOLD_UB = 6'h3F, DESEL = 6'h1E;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        oen = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [14:0] addr;
   logic [15:0] dq;
   logic [15:0] dq_out;
   logic [1:0]  dq_oe;
   sdpr_ctl_s   ctl;
   logic [31:0] rd;
   logic        err;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #10 clk = ~clk;
   sdpr_host_model h (.i_clock(clk), .o_addr(addr), .o_dq(dq), .o_ctl(ctl));
   sdpr_top DUT (
      .I_CLOCK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_DQ(dq), .I_CTL(ctl), .I_OUTPUT_EN_N(oen),
      .O_DQ(dq_out), .O_DQ_OE(dq_oe), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Access phase lasts until ready is seen high at a rising edge
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic see(input logic [15:0] e, input logic [1:0] oe);
      logic [15:0] m;
      #1;
      m = {{8{oe[1]}}, {8{oe[0]}}};
      `CHK("port data", e & m, dq_out & m)
      `CHK("port drive", oe, dq_oe)
   endtask
   task t_burst;
      h.op(WR_LD, 15'h5, 16'hA5C3);
      h.op(WR_ADV, 15'h0, 16'h5A3C);
      h.op(WR_LD, 15'h0, 16'h1234);
      h.op(RD_LD, 15'h5, 16'h0);
      h.op(RD_ADV, 15'h0, 16'h0);
      see(16'hA5C3, 2'h3);
      h.op(RD_HOLD, 15'h0, 16'h0);
      see(16'h5A3C, 2'h3);
      h.op(RD_CLR, 15'h0, 16'h0);
      see(16'h5A3C, 2'h3);
      h.op(RD_HOLD, 15'h0, 16'h0);
      see(16'h1234, 2'h3);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("counter", 32'h0, rd)
   endtask
   task t_bytes;
      h.op(RD_LD_UB, 15'h5, 16'h0);
      h.op(RD_HOLD_UB, 15'h0, 16'h0);
      h.op(DESEL, 15'h0, 16'h0);
      see(16'hA5C3, 2'h1);
      h.op(DESEL, 15'h0, 16'h0);
      see(16'h0, 2'h0);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("power down", 1'b1, rd[0])
      h.op(RD_LD, 15'h5, 16'h0);
      h.op(RD_HOLD, 15'h0, 16'h0);
      see(16'hA5C3, 2'h3);
      @(posedge clk);
      oen <= 1'b1;
      #2;
      `CHK("async enable", 2'h0, dq_oe)
   endtask
   task t_pipe;
      h.op(DESEL, 15'h0, 16'h0);
      oen <= 1'b0;
      // Mode is written here while the port is idle
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("mode", 1'b1, rd[1])
      h.op(RD_LD, 15'h5, 16'h0);
      h.op(RD_HOLD, 15'h0, 16'h0);
      see(16'h0, 2'h0);
      h.op(RD_HOLD, 15'h0, 16'h0);
      see(16'h0, 2'h0);
      h.op(RD_HOLD, 15'h0, 16'h0);
      see(16'hA5C3, 2'h3);
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("error", 1'b1, err)
      `CHK("error data", 32'h0, rd)
   endtask
   task results;
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_burst;
      t_bytes;
      t_pipe;
      results;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         results;
      end
   end
endmodule // sdpr_top_test
